// >>> verification/disk_ctrl_maint_commands_test.sv
`timescale 1ns/1ps
module disk_ctrl_maint_commands_test
  import dkm_pkg::*;
;
  localparam int NB = 16;
  logic core_clk, srst, userValid, userReady, rxValid, rxReady, cmdDone;
  logic [7:0] userData, rxData, lastStatus, configJumpers, driveFill;
  logic tapePresentJumper, spareJumper, sectorReadDone, driveFillFromBuf;
  logic [NB*8-1:0] diskSector, eccSyndrome;
  logic [2:0] driveOp;
  logic [23:0] driveTrack, driveAltAddr, seekTrk, markTrk, markAlt;
  logic [4:0] driveInterleave, fmtIlv;
  logic [1:0] driveUnitSelect, unitSel;
  logic driveStart, trackIsAlt, trackIsBad, fmtSrc;
  logic driveDone = 1'b0;
  logic [7:0] fmtFill;
  logic [11:0] opsSeq;
  int pend = 0;
  int fails = 0;
  int numChecks = 0;
  int spans[4] = '{1, 6, 11, 12};
  logic [7:0] caseSt[4] = '{ST_OK, ST_ALT_ASSIGNED, ST_BAD_TRACK, ST_OK};
  logic [7:0] idExp[6];
  dkm_link_if lif();
  dkm_host dkm_host_inst(.core_clk(core_clk), .srst(srst), .link(lif.host),
    .userData(userData), .userValid(userValid), .userReady(userReady),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .lastStatus(lastStatus), .cmdDone(cmdDone));
  dkm_device #(.BUF_BYTES(NB)) dkm_device_inst(.core_clk(core_clk),
    .srst(srst), .link(lif.device), .configJumpers(configJumpers),
    .tapePresentJumper(tapePresentJumper), .spareJumper(spareJumper),
    .diskSector(diskSector), .eccSyndrome(eccSyndrome),
    .sectorReadDone(sectorReadDone), .driveOp(driveOp),
    .driveTrack(driveTrack), .driveAltAddr(driveAltAddr),
    .driveInterleave(driveInterleave), .driveFill(driveFill),
    .driveFillFromBuf(driveFillFromBuf), .driveUnitSelect(driveUnitSelect),
    .driveStart(driveStart), .driveDone(driveDone),
    .trackIsAlt(trackIsAlt), .trackIsBad(trackIsBad));
  dkm_maint_chk #(.NB(NB)) dkm_maint_chk_inst(.core_clk(core_clk),
    .srst(srst), .hData(lif.hData), .hValid(lif.hValid),
    .hReady(lif.hReady), .dData(lif.dData), .dValid(lif.dValid),
    .dReady(lif.dReady), .status(lif.status), .done(lif.done));
  // ---------------------------------------------------------------
  // drive responder: records steps, answers each start later
  // ---------------------------------------------------------------
  always @(negedge core_clk) begin
    driveDone = (pend == 1);
    if (pend > 0) pend = pend - 1;
    if (driveStart === 1'b1) begin
      if (driveOp == DRV_SEEK) begin
        seekTrk = driveTrack;
        opsSeq = 12'h000;
      end
      opsSeq = {opsSeq[8:0], driveOp};
      if (driveOp == DRV_FMT_ALT) begin
        fmtIlv = driveInterleave;
        fmtFill = driveFill;
        fmtSrc = driveFillFromBuf;
      end
      if (driveOp == DRV_MARK_BAD) begin
        markTrk = driveTrack;
        markAlt = driveAltAddr;
      end
      unitSel = driveUnitSelect;
      pend = 3;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic put(input logic [7:0] b);
    int n = 0;
    @(negedge core_clk);
    userData = b;
    userValid = 1'b1;
    #1;
    while (userReady !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      #1;
      n++;
    end
    if (n >= 2000) chk("put wait", 0, 1);
    @(posedge core_clk);
  endtask : put
  task automatic rel;
    @(negedge core_clk);
    userValid = 1'b0;
  endtask : rel
  task automatic cmd(input logic [47:0] c);
    for (int i = 5; i >= 0; i--) put(c[i*8+:8]);
    rel();
  endtask : cmd
  task automatic get(input string nm, input logic [7:0] e, input bit cmp);
    int n = 0;
    while (rxValid !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) chk("get wait", 0, 1);
    if (cmp) chk(nm, e, rxData);
    @(negedge core_clk);
  endtask : get
  task automatic wait_done(input logic [7:0] st);
    int n = 0;
    while (cmdDone !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 5000) chk("done wait", 0, 1);
    chk("status", st, lastStatus);
  endtask : wait_done
  // ---------------------------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #600000;
    fails++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    {userData, userValid, sectorReadDone, trackIsAlt, trackIsBad} = '0;
    eccSyndrome = '0;
    rxReady = 1'b0;
    configJumpers = 8'ha7;
    tapePresentJumper = 1'b1;
    spareJumper = 1'b0;
    for (int i = 0; i < NB; i++) diskSector[i*8+:8] = 8'h40 + 8'(i);
    idExp = '{CTRL_TYPE_CODE, FW_REV, 8'ha7, 8'h01, 8'h00, 8'h00};
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    for (int j = 0; j < 2; j++) begin
      tapePresentJumper = (j == 0);
      spareJumper = (j == 1);
      idExp[3] = (j == 0) ? 8'h01 : 8'h02;
      rxReady = 1'b0;
      cmd({OP_CTRL_TYPE, 8'h80, 32'hffffffff});
      repeat (8) @(negedge core_clk);
      rxReady = 1'b1;
      for (int i = 0; i < ID_LEN; i++) get("id byte", idExp[i], 1);
      wait_done(ST_OK);
    end
    cmd({OP_WR_BUF, 40'h0});
    for (int i = 0; i < NB; i++) put(8'(i * 7 + 3));
    rel();
    wait_done(ST_OK);
    cmd({OP_RD_BUF, 40'h0});
    for (int i = 0; i < NB; i++) get("rd buf", 8'(i * 7 + 3), 1);
    wait_done(ST_OK);
    foreach (spans[k]) begin
      eccSyndrome = '0;
      eccSyndrome[3] = 1'b1;
      eccSyndrome[3+spans[k]-1] = 1'b1;
      sectorReadDone = 1'b1;
      @(negedge core_clk);
      sectorReadDone = 1'b0;
      @(negedge core_clk);
      chk("ecc status", spans[k] > ECC_LIMIT ? ST_UNCORR_ERR : ST_CORR_ERR,
        lif.status);
      cmd({OP_BURST_LEN, 40'h0});
      get("burst", 8'(spans[k]), spans[k] <= ECC_LIMIT);
      wait_done(spans[k] > ECC_LIMIT ? ST_BAD_OPCODE : ST_OK);
    end
    cmd({OP_RD_BUF, 40'h0});
    for (int i = 0; i < NB; i++) get("bad data", 8'h40 + 8'(i), 1);
    wait_done(ST_OK);
    for (int k = 0; k < 4; k++) begin
      trackIsAlt = (k == 1);
      trackIsBad = (k == 2);
      cmd({OP_FMT_ALT, 32'h22345603, 2'b00, k == 3, 5'h00});
      put(8'h01);
      put(8'h23);
      put(8'h45);
      rel();
      wait_done(caseSt[k]);
      chk("seek trk", 24'h012300, seekTrk);
      chk("steps", k == 1 || k == 2 ? 12'h001 : 12'h054, opsSeq);
      chk("unit", 2'b01, unitSel);
      if (caseSt[k] == ST_OK) begin
        chk("bad trk", 24'h023400, markTrk);
        chk("alt addr", 24'h012300, markAlt);
        chk("interleave", 5'h03, fmtIlv);
        chk("fill", k == 3 ? 8'h40 : FILL_PATTERN, fmtFill);
        chk("fill src", k == 3, fmtSrc);
      end
    end
    cmd({8'h3f, 40'h0});
    wait_done(ST_BAD_OPCODE);
    end_of_test();
  end
endmodule : disk_ctrl_maint_commands_test

// >>> verification/dkm_maint_chk.sv
`timescale 1ns/1ps
module dkm_maint_chk
  import dkm_pkg::*;
#(
  parameter int NB = BUF_LEN
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] hData,
  input wire logic hValid,
  input wire logic hReady,
  input wire logic [7:0] dData,
  input wire logic dValid,
  input wire logic dReady,
  input wire logic [7:0] status,
  input wire logic done
);
  // ---------------------------------------------------------------
  // bytes taken and sent in the current command
  // ---------------------------------------------------------------
  logic [9:0] hCnt_reg;
  logic [9:0] dCnt_reg;
  logic [7:0] op_reg;
  always_ff @(posedge core_clk) begin
    if (srst || done) begin
      hCnt_reg <= 10'h000;
      dCnt_reg <= 10'h000;
    end else begin
      if (hValid && hReady) begin
        hCnt_reg <= hCnt_reg + 10'h001;
      end
      if (dValid && dReady) begin
        dCnt_reg <= dCnt_reg + 10'h001;
      end
    end
    if (!srst && !done && hValid && hReady && hCnt_reg == 10'h000) begin
      op_reg <= hData;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_back_idle;
    ##1 (!done && hReady);
  endsequence
  done_pulse_a: assert property (
    done |-> s_back_idle) else $error("done not a single pulse");
  drain_hold_a: assert property (
    dValid && !dReady |=> dValid && $stable(dData))
    else $error("reply byte changed while stalled");
  tx_block_a: assert property (
    dValid |-> !hReady && hCnt_reg >= CMD_LEN)
    else $error("reply overlaps command intake");
  id_len_a: assert property (
    done && op_reg == OP_CTRL_TYPE |-> dCnt_reg == ID_LEN)
    else $error("identification length wrong");
  burst_len_a: assert property (
    done && op_reg == OP_BURST_LEN |-> dCnt_reg == 1)
    else $error("burst reply length wrong");
  rdbuf_len_a: assert property (
    done && op_reg == OP_RD_BUF |-> dCnt_reg == NB)
    else $error("buffer read length wrong");
  wrbuf_len_a: assert property (
    done && op_reg == OP_WR_BUF |-> hCnt_reg == CMD_LEN + NB)
    else $error("buffer write length wrong");
  alt_len_a: assert property (
    done && op_reg == OP_FMT_ALT |-> hCnt_reg == CMD_LEN + ALT_LEN)
    else $error("alternate address not fetched");
  bad_op_a: assert property (
    done && !(op_reg inside {[OP_BURST_LEN:OP_CTRL_TYPE]})
    |-> status == ST_BAD_OPCODE) else $error("bad opcode accepted");
endmodule : dkm_maint_chk

// >>> verilog/dkm_device.sv
`timescale 1ns/1ps
module dkm_device
  import dkm_pkg::*;
#(
  parameter int BUF_BYTES = BUF_LEN
) (
  input wire logic core_clk,
  input wire logic srst,
  dkm_link_if.device link,
  input wire logic [7:0] configJumpers,
  input wire logic tapePresentJumper,
  input wire logic spareJumper,
  input wire logic [BUF_BYTES*8-1:0] diskSector,
  input wire logic [BUF_BYTES*8-1:0] eccSyndrome,
  input wire logic sectorReadDone,
  output logic [2:0] driveOp,
  output logic [23:0] driveTrack,
  output logic [23:0] driveAltAddr,
  output logic [4:0] driveInterleave,
  output logic [7:0] driveFill,
  output logic driveFillFromBuf,
  output logic [1:0] driveUnitSelect,
  output logic driveStart,
  input wire logic driveDone,
  input wire logic trackIsAlt,
  input wire logic trackIsBad
);
  localparam int BW = $clog2(BUF_BYTES);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    S_CMD = 8'h01, S_ALT = 8'h02, S_SEEK_ALT = 8'h04, S_FMT = 8'h08,
    S_MARK = 8'h10, S_RX_BUF = 8'h20, S_TX = 8'h40, S_DONE = 8'h80
  } dkm_state_t;
  typedef struct packed {
    dkm_state_t state;
    logic [CMD_LEN-1:0][7:0] cmd;
    logic [2:0][7:0] alt;
    logic [BUF_BYTES-1:0][7:0] buffer;
    logic [BW:0] idx;
    logic [BW:0] txLen;
    logic [7:0] burstLen;
    logic burstValid;
    logic busy;
    logic [7:0] status;
    logic done;
    logic [2:0] driveOp;
    logic driveStart;
  } dkm_dev_t;
  dkm_dev_t s_reg;
  dkm_dev_t s_next;
  logic [7:0] txByte;
  logic txValid;
  logic txReady;
  logic [7:0] spanLen;
  logic [7:0] opcode;

  // inclusive span from first to last erroneous bit
  function automatic logic [7:0] burstSpan(input logic [BUF_BYTES*8-1:0] e);
    int first;
    int last;
    first = -1;
    last = -1;
    for (int i = 0; i < BUF_BYTES * 8; i++) begin
      if (e[i]) begin
        if (first < 0) first = i;
        last = i;
      end
    end
    if (first < 0) burstSpan = 8'h00;
    else if (last - first + 1 > 255) burstSpan = 8'hff;
    else burstSpan = 8'(last - first + 1);
  endfunction : burstSpan

  assign spanLen = burstSpan(eccSyndrome);
  assign opcode = s_reg.cmd[0];

  // ---------------------------------------------------------------
  // outgoing byte selection
  // ---------------------------------------------------------------
  always_comb begin
    txByte = 8'h00;
    case (opcode)
      OP_BURST_LEN: txByte = s_reg.burstLen;
      OP_RD_BUF: txByte = s_reg.buffer[s_reg.idx[BW-1:0]];
      OP_CTRL_TYPE: begin
        case (s_reg.idx[2:0])
          3'h0: txByte = CTRL_TYPE_CODE;
          3'h1: txByte = FW_REV;
          3'h2: txByte = configJumpers;
          3'h3: txByte = {6'h00, spareJumper, tapePresentJumper};
          default: txByte = 8'h00;
        endcase
      end
      default: txByte = 8'h00;
    endcase
  end
  assign txValid = (s_reg.state == S_TX) && (s_reg.idx < s_reg.txLen);

  dkm_skid_buf #(.WIDTH(8), .DEPTH(2)) u_txbuf (
    .core_clk(core_clk),
    .srst(srst),
    .inData(txByte),
    .inValid(txValid),
    .inReady(txReady),
    .outData(link.dData),
    .outValid(link.dValid),
    .outReady(link.dReady)
  );

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.driveStart = 1'b0;
    if (sectorReadDone) begin
      s_next.buffer = diskSector;
      if (spanLen == 8'h00) begin
        s_next.status = ST_OK;
        s_next.burstValid = 1'b0;
      end else if (spanLen <= 8'(ECC_LIMIT)) begin
        s_next.status = ST_CORR_ERR;
        s_next.burstLen = spanLen;
        s_next.burstValid = 1'b1;
      end else begin
        s_next.status = ST_UNCORR_ERR;
        s_next.burstValid = 1'b0;
      end
    end
    case (s_reg.state)
      S_CMD: begin
        if (link.hValid) begin
          s_next.cmd[s_reg.idx[2:0]] = link.hData;
          s_next.idx = s_reg.idx + 1'b1;
          if (s_reg.idx == (BW + 1)'(CMD_LEN - 1)) begin
            s_next.idx = '0;
            s_next.busy = 1'b1;
            s_next.status = ST_OK;
            case (s_reg.cmd[0])
              OP_BURST_LEN: begin
                s_next.txLen = (BW + 1)'(1);
                s_next.state = S_TX;
                if (!s_reg.burstValid) s_next.status = ST_BAD_OPCODE;
              end
              OP_FMT_ALT: s_next.state = S_ALT;
              OP_WR_BUF: s_next.state = S_RX_BUF;
              OP_RD_BUF: begin
                s_next.txLen = (BW + 1)'(BUF_BYTES);
                s_next.state = S_TX;
              end
              OP_CTRL_TYPE: begin
                s_next.txLen = (BW + 1)'(ID_LEN);
                s_next.state = S_TX;
              end
              default: begin
                s_next.status = ST_BAD_OPCODE;
                s_next.state = S_DONE;
              end
            endcase
          end
        end
      end
      S_ALT: begin
        if (link.hValid) begin
          s_next.alt[2 - s_reg.idx[1:0]] = link.hData;
          s_next.idx = s_reg.idx + 1'b1;
          if (s_reg.idx == (BW + 1)'(ALT_LEN - 1)) begin
            s_next.idx = '0;
            s_next.driveOp = DRV_SEEK;
            s_next.driveStart = 1'b1;
            s_next.state = S_SEEK_ALT;
          end
        end
      end
      S_SEEK_ALT: begin
        if (driveDone) begin
          if (trackIsAlt) begin
            s_next.status = ST_ALT_ASSIGNED;
            s_next.state = S_DONE;
          end else if (trackIsBad) begin
            s_next.status = ST_BAD_TRACK;
            s_next.state = S_DONE;
          end else begin
            s_next.driveOp = DRV_FMT_ALT;
            s_next.driveStart = 1'b1;
            s_next.state = S_FMT;
          end
        end
      end
      S_FMT: begin
        if (driveDone) begin
          s_next.driveOp = DRV_MARK_BAD;
          s_next.driveStart = 1'b1;
          s_next.state = S_MARK;
        end
      end
      S_MARK: begin
        if (driveDone) s_next.state = S_DONE;
      end
      S_RX_BUF: begin
        if (link.hValid) begin
          s_next.buffer[s_reg.idx[BW-1:0]] = link.hData;
          s_next.idx = s_reg.idx + 1'b1;
          if (s_reg.idx == (BW + 1)'(BUF_BYTES - 1)) begin
            s_next.idx = '0;
            s_next.state = S_DONE;
          end
        end
      end
      S_TX: begin
        if (txValid && txReady) s_next.idx = s_reg.idx + 1'b1;
        if (s_reg.idx == s_reg.txLen && !link.dValid) begin
          s_next.idx = '0;
          s_next.state = S_DONE;
        end
      end
      S_DONE: begin
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
        s_next.state = S_CMD;
      end
      default: s_next.state = S_CMD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.state <= S_CMD;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.hReady = (s_reg.state == S_CMD) || (s_reg.state == S_ALT) ||
                       (s_reg.state == S_RX_BUF);
  assign link.status = s_reg.status;
  assign link.done = s_reg.done;
  assign driveOp = s_reg.driveOp;
  assign driveStart = s_reg.driveStart;
  assign driveUnitSelect = s_reg.cmd[1][6:5];
  // sector byte forced to zero; seek and format target the alternate
  assign driveTrack = (s_reg.driveOp == DRV_MARK_BAD) ?
                      {s_reg.cmd[1] & TRACK_MASK0, s_reg.cmd[2], 8'h00} :
                      driveAltAddr;
  assign driveAltAddr = {s_reg.alt[2] & TRACK_MASK0, s_reg.alt[1],
                         8'h00};
  assign driveInterleave = s_reg.cmd[4][4:0];
  assign driveFillFromBuf = s_reg.cmd[5][PAT_SEL_BIT];
  assign driveFill = s_reg.cmd[5][PAT_SEL_BIT] ? s_reg.buffer[0]
                                               : FILL_PATTERN;
endmodule : dkm_device

// >>> verilog/dkm_host.sv
`timescale 1ns/1ps
module dkm_host
  import dkm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  dkm_link_if.host link,
  input wire logic [7:0] userData,
  input wire logic userValid,
  output logic userReady,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] lastStatus,
  output logic cmdDone
);
  // ---------------------------------------------------------------
  // host passes user bytes to the link and returns replies
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hData;
    logic hValid;
    logic [7:0] rxData;
    logic rxValid;
    logic [7:0] status;
    logic done;
  } dkm_host_t;
  dkm_host_t s_reg;
  dkm_host_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = link.done;
    if (link.done) s_next.status = link.status;
    if (s_reg.hValid && link.hReady) s_next.hValid = 1'b0;
    if (userValid && (!s_reg.hValid || link.hReady)) begin
      s_next.hData = userData;
      s_next.hValid = 1'b1;
    end
    if (s_reg.rxValid && rxReady) s_next.rxValid = 1'b0;
    if (link.dValid && (!s_reg.rxValid || rxReady)) begin
      s_next.rxData = link.dData;
      s_next.rxValid = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.hData = s_reg.hData;
  assign link.hValid = s_reg.hValid;
  assign link.dReady = !s_reg.rxValid || rxReady;
  assign userReady = !s_reg.hValid || link.hReady;
  assign rxData = s_reg.rxData;
  assign rxValid = s_reg.rxValid;
  assign lastStatus = s_reg.status;
  assign cmdDone = s_reg.done;
endmodule : dkm_host

// >>> verilog/dkm_link_if.sv
`timescale 1ns/1ps
interface dkm_link_if;
  logic [7:0] hData;
  logic hValid;
  logic hReady;
  logic [7:0] dData;
  logic dValid;
  logic dReady;
  logic [7:0] status;
  logic done;
  modport device (
    input hData, hValid, dReady,
    output hReady, dData, dValid, status, done
  );
  modport host (
    output hData, hValid, dReady,
    input hReady, dData, dValid, status, done
  );
endinterface : dkm_link_if

// >>> verilog/dkm_pkg.sv
package dkm_pkg;
  // ---------------------------------------------------------------
  // opcodes and status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_BURST_LEN = 8'h0d;
  localparam logic [7:0] OP_FMT_ALT = 8'h0e;
  localparam logic [7:0] OP_WR_BUF = 8'h0f;
  localparam logic [7:0] OP_RD_BUF = 8'h10;
  localparam logic [7:0] OP_CTRL_TYPE = 8'h11;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_TRACK = 8'h19;
  localparam logic [7:0] ST_ALT_ASSIGNED = 8'h1d;
  localparam logic [7:0] ST_BAD_OPCODE = 8'h20;
  localparam logic [7:0] ST_CORR_ERR = 8'h18;
  localparam logic [7:0] ST_UNCORR_ERR = 8'h11;
  // ---------------------------------------------------------------
  // sizes and fields
  // ---------------------------------------------------------------
  localparam int CMD_LEN = 6;
  localparam int ALT_LEN = 3;
  localparam int ID_LEN = 6;
  localparam int BUF_LEN = 256;
  localparam int ECC_LIMIT = 11;
  localparam logic [7:0] FILL_PATTERN = 8'h6c;
  localparam int PAT_SEL_BIT = 5;
  localparam logic [7:0] TRACK_MASK0 = 8'h1f;
  localparam logic [7:0] CTRL_TYPE_CODE = 8'h5a; // arbitrary value
  localparam logic [7:0] FW_REV = 8'h01; // arbitrary value
  localparam int FLAG_ALT_ASSIGNED = 0;
  localparam int FLAG_BAD_TRACK = 1;
  localparam int FLAG_IS_ALT = 2;
  // ---------------------------------------------------------------
  // drive-side command codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DRV_SEEK = 3'h1,
    DRV_FMT_ALT = 3'h2,
    DRV_MARK_BAD = 3'h4
  } dkm_drv_op_t;
endpackage : dkm_pkg

// >>> verilog/dkm_skid_buf.sv
`timescale 1ns/1ps
module dkm_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
  } dkm_fifo_t;
  dkm_fifo_t s_reg;
  dkm_fifo_t s_next;
  logic doWr;
  logic doRd;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign inReady = (s_reg.count != (AW + 1)'(DEPTH));
  assign outValid = (s_reg.count != '0);
  assign outData = s_reg.mem[s_reg.rdPtr];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_comb begin
    s_next = s_reg;
    if (doWr) begin
      s_next.mem[s_reg.wrPtr] = inData;
      s_next.wrPtr = bump(s_reg.wrPtr);
    end
    if (doRd) begin
      s_next.rdPtr = bump(s_reg.rdPtr);
    end
    if (doWr && !doRd) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (doRd && !doWr) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : dkm_skid_buf
